// ---- bench/exerr_sys_model.sv ----
// exerr_sys_model: external interrupt source plus handler entry recorder
// assumes: bench raises req/req_vec; device accepts with ext_ack pulse
`timescale 1ns/1ps

module exerr_sys_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench side
  input wire logic req,
  input wire logic [7:0] req_vec,
  // request toward the device
  output logic ext_irq,
  output logic [7:0] ext_vector,
  input wire logic ext_ack,
  // handler entry from the device
  input wire exerr_pkg::exerr_result_t entry,
  input wire logic [31:0] entry_code,
  input wire logic [31:0] entry_ip,
  input wire logic default_resp,
  // record of what arrived
  output int n_ent,
  output int n_def,
  output exerr_pkg::exerr_result_t got,
  output logic [31:0] got_code,
  output logic [31:0] got_ip
);
  logic done_q;
  logic irq_q;
  logic [7:0] vec_q;

  // the ack pulse drops the level at once, so one request is taken once
  assign ext_irq = irq_q && !ext_ack;

  // ==================================================================
  // request is a level held until accepted; withdrawn after the ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'h0;
      done_q <= 1'h0;
      vec_q <= 8'h00;
    end else begin
      irq_q <= req && !done_q && !ext_ack;
      done_q <= req && (done_q || ext_ack);
      if (req && !ext_irq) vec_q <= req_vec;
    end
  end

  // idle vector lines show the inverse so a stale value never matches
  assign ext_vector = ext_irq ? vec_q : ~vec_q;

  // handler side: keep the last entry, count entries and default replies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_ent <= 0;
      n_def <= 0;
      got <= '0;
      got_code <= 32'h0;
      got_ip <= 32'h0;
    end else begin
      if (entry.valid) begin
        n_ent <= n_ent + 1;
        got <= entry;
        got_code <= entry_code;
        got_ip <= entry_ip;
      end
      if (default_resp) n_def <= n_def + 1;
    end
  end
endmodule : exerr_sys_model

// ---- bench/testbench.sv ----
// testbench: register and event sequences against exerr_unit
// assumes: zero wait AHB slave, entry one cycle after the event edge
`timescale 1ns/1ps
`include "exerr_params.svh"

module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, mem_addr, cur_ip, next_ip, tsw_new_ip;
  logic [31:0] entry_code, entry_ip, got_code, got_ip;
  logic mem_ref, insn_boundary, hw_error, simd_exc, swi_valid, ext_irq;
  logic ext_ack, tsw_fault, tsw_is_pf, tsw_done, default_resp, req;
  logic [5:0] simd_status, simd_mask;
  logic [7:0] swi_vector, ext_vector, req_vec;
  exerr_pkg::exerr_dtype_t mem_dtype;
  exerr_pkg::exerr_result_t entry, got;
  int n_ent, n_def, base, dbase, failures, checks;
  int al[13] = '{1, 2, 4, 8, 16, 8, 2, 4, 2, 4, 4, 8, 8};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  exerr_unit dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .mem_ref, .mem_addr, .mem_dtype,
    .cur_ip, .next_ip, .insn_boundary, .hw_error, .simd_exc, .simd_status,
    .simd_mask, .swi_valid, .swi_vector, .ext_irq, .ext_vector, .ext_ack,
    .tsw_fault, .tsw_is_pf, .tsw_done, .tsw_new_ip, .entry, .entry_code,
    .entry_ip, .default_resp
  );

  exerr_sys_model model (
    .hclk, .hresetn, .req, .req_vec, .ext_irq, .ext_vector, .ext_ack,
    .entry, .entry_code, .entry_ip, .default_resp, .n_ent, .n_def, .got,
    .got_code, .got_ip
  );

  // ==================================================================
  // verdict and comparison
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ==================================================================
  // bus master: hready and read data sampled at the closing rising edge
  task automatic wait_rdy(output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'h1) begin
      n++;
      if (n > 50) begin
        failures++;
        report_and_stop;
      end
      @(posedge hclk);
    end
    r = hrdata;
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic [31:0] x;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy(x);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(r);
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'h0, a, 32'h0, x);
    chk(x, e);
  endtask : rd

  // ==================================================================
  // pipeline events: one cycle pulses launched at a rising edge
  task automatic start;
    @(posedge hclk);
    base = n_ent;
    dbase = n_def;
  endtask : start

  task automatic clr;
    @(posedge hclk);
    mem_ref <= 1'h0;
    hw_error <= 1'h0;
    simd_exc <= 1'h0;
    swi_valid <= 1'h0;
    tsw_fault <= 1'h0;
    tsw_done <= 1'h0;
  endtask : clr

  task automatic mref(input logic [3:0] t, input logic [31:0] a);
    start;
    mem_ref <= 1'h1;
    mem_dtype <= exerr_pkg::exerr_dtype_t'(t);
    mem_addr <= a;
    clr;
  endtask : mref

  // 0 hw error, 1 software vector, 2 switch fault, 3 switch done, else fp
  task automatic ev(input int w, input logic [7:0] v);
    start;
    case (w)
      0: hw_error <= 1'h1;
      1: swi_valid <= 1'h1;
      2: tsw_fault <= 1'h1;
      3: tsw_done <= 1'h1;
      default: simd_exc <= 1'h1;
    endcase
    swi_vector <= v;
    clr;
  endtask : ev

  task automatic got_ent(input logic [7:0] v, input logic [1:0] k,
                         input logic hc, input logic [31:0] c,
                         input logic [31:0] ip);
    int n;
    n = 0;
    while (n_ent == base) begin
      n++;
      if (n > 20) begin
        failures++;
        report_and_stop;
      end
      @(negedge hclk);
    end
    chk(n_ent - base, 32'h1);
    chk(got.vector, v);
    chk(got.kind, k);
    chk(got.has_code, hc);
    if (hc) chk(got_code, c);
    chk(got_ip, ip);
    @(posedge hclk);
  endtask : got_ent

  // answer is due the next cycle, so four quiet cycles mean none
  task automatic no_ent;
    repeat (4) @(negedge hclk);
    chk(n_ent - base, 32'h0);
    @(posedge hclk);
  endtask : no_ent

  // ==================================================================
  // main sequence
  initial begin
    int i;
    hclk = 1'h0; hresetn = 1'h0; hsel = 1'h0; haddr = 12'h0;
    htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2; hwdata = 32'h0;
    mem_ref = 1'h0; mem_addr = 32'h0; mem_dtype = exerr_pkg::DT_BYTE;
    cur_ip = 32'h0000_2468; next_ip = 32'h0000_246c; insn_boundary = 1'h1;
    hw_error = 1'h0; simd_exc = 1'h0; simd_status = 6'h0; simd_mask = 6'h0;
    swi_valid = 1'h0; swi_vector = 8'h0; tsw_fault = 1'h0; tsw_is_pf = 1'h0;
    tsw_done = 1'h0; tsw_new_ip = 32'h0; req = 1'h0; req_vec = 8'h0;
    failures = 0; checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(`EXERR_CTRL_OFF, 32'h0);
    rd(`EXERR_CPU_OFF, 32'h0);
    wr(12'h0fc, 32'hffff_ffff);
    rd(12'h0fc, 32'h0);
    mref(4'h1, 32'h101);
    no_ent;
    // one enable or a lower privilege level must keep the check off
    wr(`EXERR_CTRL_OFF, 32'h1);
    wr(`EXERR_CPU_OFF, 32'h9);
    mref(4'h1, 32'h101);
    no_ent;
    wr(`EXERR_CPU_OFF, 32'hc);
    mref(4'h1, 32'h101);
    no_ent;
    wr(`EXERR_CTRL_OFF, 32'h0);
    wr(`EXERR_CPU_OFF, 32'hd);
    mref(4'h1, 32'h101);
    no_ent;
    wr(`EXERR_CTRL_OFF, 32'h1);
    for (i = 1; i < 13; i++) begin
      mref(i[3:0], 32'h100 + al[i] / 2);
      got_ent(8'h11, exerr_pkg::KIND_FAULT, 1'h1, 32'h0, cur_ip);
      mref(i[3:0], 32'h100 + al[i]);
      no_ent;
    end
    // hardware error abort, gated by its enable, pointer per valid flag
    wr(`EXERR_CTRL_OFF, 32'h0);
    ev(0, 8'h0);
    no_ent;
    wr(`EXERR_CTRL_OFF, 32'h2);
    wr(`EXERR_CPU_OFF, 32'h10);
    ev(0, 8'h0);
    got_ent(8'h12, exerr_pkg::KIND_ABORT, 1'h0, 32'h0, cur_ip);
    wr(`EXERR_CPU_OFF, 32'h0);
    ev(0, 8'h0);
    got_ent(8'h12, exerr_pkg::KIND_ABORT, 1'h0, 32'h0, 32'h0);
    // every fp cause, open then masked
    wr(`EXERR_CTRL_OFF, 32'h4);
    for (i = 0; i < 6; i++) begin
      simd_status <= 6'h01 << i;
      simd_mask <= 6'h3f ^ (6'h01 << i);
      ev(4, 8'h0);
      got_ent(8'h13, exerr_pkg::KIND_FAULT, 1'h0, 32'h0, cur_ip);
      simd_mask <= 6'h01 << i;
      ev(4, 8'h0);
      no_ent;
      chk(n_def - dbase, 32'h1);
    end
    wr(`EXERR_CTRL_OFF, 32'h0);
    simd_mask <= 6'h00;
    ev(4, 8'h0);
    got_ent(8'h06, exerr_pkg::KIND_FAULT, 1'h0, 32'h0, cur_ip);
    // software vector ignores the irq enable; external one obeys it
    ev(1, 8'h40);
    got_ent(8'h40, exerr_pkg::KIND_INTR, 1'h0, 32'h0, next_ip);
    start;
    req_vec <= 8'hff;
    req <= 1'h1;
    no_ent;
    insn_boundary <= 1'h0;
    wr(`EXERR_CPU_OFF, 32'h2);
    start;
    no_ent;
    insn_boundary <= 1'h1;
    got_ent(8'hff, exerr_pkg::KIND_INTR, 1'h0, 32'h0, next_ip);
    repeat (3) @(posedge hclk);
    chk(ext_irq, 32'h0);
    chk(n_ent - base, 32'h1);
    req <= 1'h0;
    repeat (2) @(posedge hclk);
    start;
    req_vec <= 8'h1f;
    req <= 1'h1;
    no_ent;
    req <= 1'h0;
    // task switch faults wait for the state load to finish
    tsw_is_pf <= 1'h1;
    tsw_new_ip <= 32'h0000_8000;
    wr(`EXERR_PFREQ_OFF, 32'h07);
    wr(`EXERR_SELREQ_OFF, 32'h1d);
    ev(2, 8'h0);
    no_ent;
    ev(3, 8'h0);
    got_ent(8'h0e, exerr_pkg::KIND_FAULT, 1'h1, 32'h07, tsw_new_ip);
    tsw_is_pf <= 1'h0;
    ev(2, 8'h0);
    no_ent;
    ev(3, 8'h0);
    got_ent(8'h0a, exerr_pkg::KIND_FAULT, 1'h1, 32'h1d, tsw_new_ip);
    wr(`EXERR_CTRL_OFF, 32'h40);
    ev(2, 8'h0);
    ev(3, 8'h0);
    no_ent;
    // error code builder: extension bits qualify the upper page bits
    wr(`EXERR_PFREQ_OFF, 32'h1f);
    wr(`EXERR_CTRL_OFF, 32'h18);
    wr(`EXERR_EVT_OFF, 32'h1);
    rd(`EXERR_ECODE_OFF, 32'h1f);
    wr(`EXERR_CTRL_OFF, 32'h20);
    wr(`EXERR_EVT_OFF, 32'h1);
    rd(`EXERR_ECODE_OFF, 32'h0f);
    wr(`EXERR_CTRL_OFF, 32'h0);
    wr(`EXERR_EVT_OFF, 32'h1);
    rd(`EXERR_ECODE_OFF, 32'h07);
    wr(`EXERR_SELREQ_OFF, 32'hffff);
    wr(`EXERR_EVT_OFF, 32'h2);
    rd(`EXERR_ECODE_OFF, 32'hfffb);
    report_and_stop;
  end
endmodule : testbench

// ---- inc/exerr_params.svh ----
// exerr_params.svh: offsets, field positions, reset values, vector numbers
// assumes: included by the testbench and design; definitions only
`ifndef EXERR_PARAMS_SVH
`define EXERR_PARAMS_SVH

// ====================================================================
// register byte offsets (AHB-Lite word aligned)
`define EXERR_CTRL_OFF 12'h000
`define EXERR_CPU_OFF 12'h004
`define EXERR_EVT_OFF 12'h008
`define EXERR_PFREQ_OFF 12'h00c
`define EXERR_SELREQ_OFF 12'h010
`define EXERR_RESULT_OFF 12'h014
`define EXERR_ECODE_OFF 12'h018
`define EXERR_RIP_OFF 12'h01c
`define EXERR_STAT_OFF 12'h020

// ====================================================================
// control register bit positions
`define EXERR_CTRL_AM 0
`define EXERR_CTRL_MCE 1
`define EXERR_CTRL_OSXF 2
`define EXERR_CTRL_NXE 3
`define EXERR_CTRL_PAE 4
`define EXERR_CTRL_PSE 5
`define EXERR_CTRL_LONG 6
`define EXERR_CTRL_RESET 32'h0000_0000

// cpu state register bit positions
`define EXERR_CPU_AC 0
`define EXERR_CPU_IF 1
`define EXERR_CPU_CPL_LO 2
`define EXERR_CPU_SAVED_POINTER_VALID 4
`define EXERR_CPU_RESET 32'h0000_0000

// ====================================================================
// vectors and figures
`define EXERR_VEC_UD 8'h06
`define EXERR_VEC_PF 8'h0e
`define EXERR_VEC_AC 8'h11
`define EXERR_VEC_MC 8'h12
`define EXERR_VEC_XF 8'h13
`define EXERR_VEC_USER_MIN 8'h20
`define EXERR_CPL_USER 2'h3

// selector error code fields
`define EXERR_SEL_EXT 0
`define EXERR_SEL_IDT 1
`define EXERR_SEL_TI 2
`define EXERR_SEL_IDX_LO 3

// page fault error code fields
`define EXERR_PF_P 0
`define EXERR_PF_RW 1
`define EXERR_PF_US 2
`define EXERR_PF_RSV 3
`define EXERR_PF_ID 4

`endif

// ---- inc/exerr_pkg.sv ----
// exerr_pkg: types shared by the exception and error code logic
// assumes: exerr_params.svh holds the numeric constants
package exerr_pkg;

  // ====================================================================
  // data types checked for alignment
  typedef enum logic [3:0] {
    DT_BYTE = 4'h0,
    DT_WORD = 4'h1,
    DT_DWORD = 4'h2,
    DT_QWORD = 4'h3,
    DT_MEDIA128 = 4'h4,
    DT_MEDIA64 = 4'h5,
    DT_SELECTOR = 4'h6,
    DT_NEAR32 = 4'h7,
    DT_FAR32 = 4'h8,
    DT_FAR48 = 4'h9,
    DT_FP_SINGLE = 4'ha,
    DT_FP_DOUBLE = 4'hb,
    DT_FP_EXT = 4'hc
  } exerr_dtype_t;

  // event delivery machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TSW_LOAD = 2'b01,
    ST_REPORT = 2'b10
  } exerr_state_t;

  // kind of outcome
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_FAULT = 2'b01,
    KIND_ABORT = 2'b10,
    KIND_INTR = 2'b11
  } exerr_kind_t;

  // one delivered event
  typedef struct packed {
    logic valid;
    exerr_kind_t kind;
    logic has_code;
    logic [7:0] vector;
  } exerr_result_t;

  // ahb address phase capture
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
  } exerr_ahb_req_t;

endpackage : exerr_pkg

// ---- rtl/exerr_unit.sv ----
// exerr_unit: exception detection and error code builder for a processor
// assumes: one 100 MHz clock, AHB-Lite slave, pipeline strobes synchronous
//
// Summary of operation
// RL1: misalign fault only with both align enables set and privilege level 3
// RL2: after reset both align enables are clear, so misalign is off
// RL3: alignment boundary per data type: 2,4,8,16 bytes as tabulated
// RL4: misalign fault vector 17, fault type, error code zero, ip of instr
// RL5: hardware error abort vector 18 only if enabled, abort, no code
// RL6: saved pointer valid flag says whether saved ip names failing instr
// RL7: vector fp fault vector 19 needs status set, mask clear, os support
// RL8: unmasked vector fp with os support 0 takes bad opcode vector
// RL9: masked vector fp takes default response, no handler entry
// RL10: vector fp fault precise, no error code, ip of causing instr
// RL11: user vectors 32-255 from external request or software instruction
// RL12: software should keep vectors 0-31 for defined purposes
// RL13: external at boundary saves next ip; software saves ip after it
// RL14: irq enable gates external requests; software ones never masked
// RL15: task switch fault waits for state load, ip is new task start
// RL16: in long mode task switch exceptions cannot arise
// RL17: page fault format for page faults, selector format otherwise
// RL18: selector code: bit0 external, bit1 table, bit2 local, 15:3 index
// RL19: local select bit meaningful only when table flag is 0
// RL20: page code: bit0 protection, bit1 write, bit2 user access
// RL21: page code bit3 reserved bit, only with large page or wide ext
// RL22: page code bit4 fetch, only with no exec and wide ext
`timescale 1ns/1ps
`include "exerr_params.svh"

module exerr_unit #(
  parameter int ADDR_W = 12,
  parameter int IP_W = 32
) (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pipeline events
  input wire logic mem_ref,
  input wire logic [IP_W-1:0] mem_addr,
  input wire exerr_pkg::exerr_dtype_t mem_dtype,
  input wire logic [IP_W-1:0] cur_ip,
  input wire logic [IP_W-1:0] next_ip,
  input wire logic insn_boundary,
  input wire logic hw_error,
  input wire logic simd_exc,
  input wire logic [5:0] simd_status,
  input wire logic [5:0] simd_mask,
  input wire logic swi_valid,
  input wire logic [7:0] swi_vector,
  // external system interrupt logic
  input wire logic ext_irq,
  input wire logic [7:0] ext_vector,
  output logic ext_ack,
  // task switch engine
  input wire logic tsw_fault,
  input wire logic tsw_is_pf,
  input wire logic tsw_done,
  input wire logic [IP_W-1:0] tsw_new_ip,
  // handler entry
  output exerr_pkg::exerr_result_t entry,
  output logic [31:0] entry_code,
  output logic [IP_W-1:0] entry_ip,
  output logic default_resp
);

  initial begin
    if (ADDR_W < 6 || IP_W < 8 || IP_W > 32) begin
      $error("exerr_unit: unsupported parameter values");
    end
  end

  // ====================================================================
  // alignment boundary as low-address mask
  function automatic logic [3:0] align_mask(exerr_pkg::exerr_dtype_t t);
    case (t)
      exerr_pkg::DT_WORD, exerr_pkg::DT_SELECTOR,
      exerr_pkg::DT_FAR32: align_mask = 4'h1;
      exerr_pkg::DT_DWORD, exerr_pkg::DT_NEAR32, exerr_pkg::DT_FAR48,
      exerr_pkg::DT_FP_SINGLE: align_mask = 4'h3;
      exerr_pkg::DT_QWORD, exerr_pkg::DT_MEDIA64, exerr_pkg::DT_FP_DOUBLE,
      exerr_pkg::DT_FP_EXT: align_mask = 4'h7;
      exerr_pkg::DT_MEDIA128: align_mask = 4'hf;
      default: align_mask = 4'h0;
    endcase
  endfunction : align_mask

  // ====================================================================
  // registers
  logic [31:0] ctrl_q;
  logic [31:0] cpu_q;
  logic [31:0] pfreq_q;
  logic [31:0] selreq_q;
  logic [31:0] ecode_q;
  logic [31:0] stat_q;
  logic evt_pf_go;
  logic evt_sel_go;
  exerr_pkg::exerr_ahb_req_t req_q;
  exerr_pkg::exerr_state_t state_q;
  exerr_pkg::exerr_result_t res_d;
  logic [IP_W-1:0] ip_d;
  logic [31:0] code_d;
  logic tsw_is_pf_q;

  wire logic am = ctrl_q[`EXERR_CTRL_AM];
  wire logic mce = ctrl_q[`EXERR_CTRL_MCE];
  wire logic osxf = ctrl_q[`EXERR_CTRL_OSXF];
  wire logic nxe = ctrl_q[`EXERR_CTRL_NXE];
  wire logic pae = ctrl_q[`EXERR_CTRL_PAE];
  wire logic pse = ctrl_q[`EXERR_CTRL_PSE];
  wire logic long_mode = ctrl_q[`EXERR_CTRL_LONG];
  wire logic acf = cpu_q[`EXERR_CPU_AC];
  wire logic irq_en = cpu_q[`EXERR_CPU_IF];
  wire logic [1:0] current_privilege_level = cpu_q[`EXERR_CPU_CPL_LO +: 2];
  wire logic saved_pointer_valid = cpu_q[`EXERR_CPU_SAVED_POINTER_VALID];

  // ====================================================================
  // ahb address phase capture; zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.wr <= hsel && htrans[1] && hwrite;
      req_q.rd <= hsel && htrans[1] && !hwrite;
      req_q.addr <= {haddr[11:2], 2'b00};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // control and cpu state writes; reset clears align enables [RL2]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `EXERR_CTRL_RESET; // [RL2]
      cpu_q <= `EXERR_CPU_RESET; // [RL2]
      pfreq_q <= '0;
      selreq_q <= '0;
    end else if (req_q.wr) begin
      case (req_q.addr)
        `EXERR_CTRL_OFF: ctrl_q <= {25'h0, hwdata[6:0]};
        `EXERR_CPU_OFF: cpu_q <= {27'h0, hwdata[4:0]};
        `EXERR_PFREQ_OFF: pfreq_q <= {27'h0, hwdata[4:0]};
        `EXERR_SELREQ_OFF: selreq_q <= {16'h0, hwdata[15:0]};
        default: ;
      endcase
    end
  end

  // writing the event register with bit0/bit1 builds a code
  assign evt_pf_go = req_q.wr && req_q.addr == `EXERR_EVT_OFF && hwdata[0];
  assign evt_sel_go = req_q.wr && req_q.addr == `EXERR_EVT_OFF
    && hwdata[1];

  // ====================================================================
  // read mux; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0;
    if (req_q.rd) begin
      case (req_q.addr)
        `EXERR_CTRL_OFF: hrdata = ctrl_q;
        `EXERR_CPU_OFF: hrdata = cpu_q;
        `EXERR_PFREQ_OFF: hrdata = pfreq_q;
        `EXERR_SELREQ_OFF: hrdata = selreq_q;
        `EXERR_RESULT_OFF: hrdata = {20'h0, entry};
        `EXERR_ECODE_OFF: hrdata = ecode_q;
        `EXERR_RIP_OFF: hrdata = 32'(entry_ip);
        `EXERR_STAT_OFF: hrdata = stat_q;
        default: hrdata = 32'h0;
      endcase
    end
  end

  // ====================================================================
  // error code builders; pfreq bits: p,rw,us,rsv,fetch
  function automatic logic [31:0] pf_code(logic [4:0] r, logic ps,
                                          logic pa, logic nx);
    pf_code = 32'h0;
    pf_code[`EXERR_PF_P] = r[0]; // [RL20]
    pf_code[`EXERR_PF_RW] = r[1]; // [RL20]
    pf_code[`EXERR_PF_US] = r[2]; // [RL20]
    pf_code[`EXERR_PF_RSV] = r[3] && (ps || pa); // [RL21]
    pf_code[`EXERR_PF_ID] = r[4] && nx && pa; // [RL22]
  endfunction : pf_code

  // selreq bits: ext, idt, ti, index 15:3
  function automatic logic [31:0] sel_code(logic [15:0] r);
    sel_code = {16'h0, r[15:3], 3'b000}; // [RL18]
    sel_code[`EXERR_SEL_EXT] = r[0]; // [RL18]
    sel_code[`EXERR_SEL_IDT] = r[1]; // [RL18]
    sel_code[`EXERR_SEL_TI] = r[1] ? 1'b0 : r[2]; // [RL19]
  endfunction : sel_code

  // ====================================================================
  // event detection and priority among this block's sources
  wire logic misalign = mem_ref && am && acf && current_privilege_level == `EXERR_CPL_USER
    && |(mem_addr[3:0] & align_mask(mem_dtype)); // [RL1] [RL3]
  wire logic simd_unmasked = simd_exc && |(simd_status & ~simd_mask);
  wire logic simd_masked = simd_exc && !simd_unmasked;
  wire logic ext_take = ext_irq && irq_en && insn_boundary
    && ext_vector >= `EXERR_VEC_USER_MIN; // [RL11] [RL14]
  wire logic tsw_take = tsw_fault && !long_mode; // [RL16]

  always_comb begin
    res_d = '0;
    ip_d = cur_ip;
    code_d = 32'h0;
    if (hw_error && mce) begin
      res_d = '{1'b1, exerr_pkg::KIND_ABORT, 1'b0, `EXERR_VEC_MC}; // [RL5]
      ip_d = saved_pointer_valid ? cur_ip : '0; // [RL6]
    end else if (misalign) begin
      res_d = '{1'b1, exerr_pkg::KIND_FAULT, 1'b1, `EXERR_VEC_AC}; // [RL4]
    end else if (simd_unmasked) begin
      res_d = '{1'b1, exerr_pkg::KIND_FAULT, 1'b0,
                osxf ? `EXERR_VEC_XF : `EXERR_VEC_UD}; // [RL7] [RL8] [RL10]
    end else if (swi_valid) begin
      res_d = '{1'b1, exerr_pkg::KIND_INTR, 1'b0, swi_vector}; // [RL11]
      ip_d = next_ip; // [RL13]
    end else if (ext_take) begin
      res_d = '{1'b1, exerr_pkg::KIND_INTR, 1'b0, ext_vector}; // [RL14]
      ip_d = next_ip; // [RL13]
    end
  end

  // ====================================================================
  // delivery machine: task-switch faults wait for state load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= exerr_pkg::ST_IDLE;
      tsw_is_pf_q <= 1'b0;
    end else begin
      case (state_q)
        exerr_pkg::ST_IDLE: begin
          if (tsw_take) begin
            state_q <= exerr_pkg::ST_TSW_LOAD; // [RL15]
            tsw_is_pf_q <= tsw_is_pf;
          end
        end
        exerr_pkg::ST_TSW_LOAD: begin
          if (tsw_done) begin
            state_q <= exerr_pkg::ST_REPORT; // [RL15]
          end
        end
        exerr_pkg::ST_REPORT: state_q <= exerr_pkg::ST_IDLE;
        default: state_q <= exerr_pkg::ST_IDLE;
      endcase
    end
  end

  // handler entry outputs; one-cycle entry.valid pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry <= '0;
      entry_ip <= '0;
      entry_code <= 32'h0;
      ext_ack <= 1'b0;
      default_resp <= 1'b0;
    end else if (state_q == exerr_pkg::ST_REPORT) begin
      entry <= '{1'b1, exerr_pkg::KIND_FAULT, 1'b1,
                 tsw_is_pf_q ? `EXERR_VEC_PF : 8'h0a}; // [RL15]
      entry_ip <= tsw_new_ip; // [RL15]
      entry_code <= tsw_is_pf_q ? pf_code(pfreq_q[4:0], pse, pae, nxe)
                                : sel_code(selreq_q[15:0]); // [RL17]
      ext_ack <= 1'b0;
      default_resp <= 1'b0;
    end else begin
      entry <= res_d;
      entry_ip <= ip_d;
      entry_code <= code_d; // zero for misalign [RL4]
      ext_ack <= ext_take && !(hw_error && mce) && !misalign
        && !simd_unmasked && !swi_valid;
      default_resp <= simd_masked; // [RL9]
    end
  end

  // software-built error code register and status copy of the delivery state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ecode_q <= 32'h0;
      stat_q <= 32'h0;
    end else begin
      if (evt_pf_go) begin
        ecode_q <= pf_code(pfreq_q[4:0], pse, pae, nxe); // [RL17]
      end else if (evt_sel_go) begin
        ecode_q <= sel_code(selreq_q[15:0]); // [RL17]
      end
      stat_q <= {30'h0, state_q};
    end
  end

  // ====================================================================
  // assertions
  AST_MISALIGN_CPL: assert property (@(posedge hclk) disable iff (!hresetn)
    (entry.valid && entry.vector == `EXERR_VEC_AC)
      |-> $past(current_privilege_level) == `EXERR_CPL_USER && $past(am) && $past(acf)) // [RL1]
    else $error("misalign below user level");
  AST_MISALIGN_CODE: assert property (@(posedge hclk) disable iff (!hresetn)
    (entry.valid && entry.vector == `EXERR_VEC_AC)
      |-> entry_code == 32'h0 && entry_ip == $past(cur_ip)) // [RL4]
    else $error("misalign code or ip wrong");
  AST_HWERR_EN: assert property (@(posedge hclk) disable iff (!hresetn)
    (entry.valid && entry.kind == exerr_pkg::KIND_ABORT) |-> $past(mce))
    // [RL5]
    else $error("abort while disabled");
  AST_SIMD_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
    (simd_unmasked && !hw_error && !misalign && state_q
      == exerr_pkg::ST_IDLE) |=> entry.vector
      == ($past(osxf) ? `EXERR_VEC_XF : `EXERR_VEC_UD)) // [RL8]
    else $error("wrong simd vector");
  AST_SIMD_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
    (simd_masked && !hw_error && !misalign && !swi_valid && !ext_take
      && state_q == exerr_pkg::ST_IDLE) |=> !entry.valid && default_resp)
    // [RL9]
    else $error("masked simd entered handler");
  AST_EXT_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_ack |-> $past(irq_en) && $past(insn_boundary)) // [RL14]
    else $error("external irq taken while masked");
  AST_SWI_IP: assert property (@(posedge hclk) disable iff (!hresetn)
    (swi_valid && !hw_error && !misalign && !simd_unmasked
      && state_q == exerr_pkg::ST_IDLE) |=> entry.valid
      && entry_ip == $past(next_ip)) // [RL13]
    else $error("software interrupt ip wrong");
  AST_TSW_LONG: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == exerr_pkg::ST_IDLE && long_mode) |=> state_q
      == exerr_pkg::ST_IDLE) // [RL16]
    else $error("task switch fault in long mode");
  AST_TSW_IP: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == exerr_pkg::ST_REPORT |=> entry.valid
      && entry_ip == $past(tsw_new_ip)) // [RL15]
    else $error("task switch entry ip wrong");
  AST_TI_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(evt_sel_go) && selreq_q[1] |=> ecode_q[`EXERR_SEL_TI] == 1'b0)
    // [RL19]
    else $error("local select set with table flag");

endmodule : exerr_unit
